/* rtl/lvds_pixel_packet_serializer.sv */
// How it works
// - line-active output has three formats picked by a two-bit field
// - third format drives continuous line-active xor frame-active
// - packets are 12 bits stand-alone, 18 bits in stereo
// - serial stream carries own data alone or merged with slave data
// - stand-alone packet: start one at bit 0, stop zero at bit 11
// - 8-bit mode: bits 1-8 pixel 2-9, bit 9 line, bit 10 frame
// - 10-bit mode: bits 1-10 carry pixel bits 0-9
// - stereo packet: start one at bit 0, stop zero at bit 17
// - stereo bits 1-8 master byte, bits 9-16 slave byte
// - line and frame timing always embedded as reserved words
// - word 0 before frame start, word 1 before line start
// - word 2 after line end, word 3 after frame end
// - pixels equal to 0..3 are sent as 4
// - bin two sends every packet twice in a row
// - bin four sends every packet four times in a row
// - paired sensors share clock and reset so they run in lock-step
// - control register settings take effect on both sensors at the same frame boundary; link register writes apply at once
// - master flags a sync error when merged streams disagree and either byte is a reserved word
`timescale 1ns/10ps
`include "lvds_serializer_defines.svh"

module lvds_pixel_packet_serializer
(
  input  wire logic        sys_clk_i,     // system clock
  input  wire logic        nrst_i,        // sync reset, active low
  input  wire logic [3:0]  addr_i,        // register byte address
  input  wire logic [31:0] wdata_i,       // register write data
  input  wire logic        wr_i,          // write strobe
  input  wire logic        rd_i,          // read strobe
  output logic      [31:0] rdata_o,       // read data, cycle after rd_i
  input  wire logic [9:0]  pixel_i,       // pixel value from the core
  input  wire logic        pixel_vld_i,   // pixel word offered
  input  wire logic        line_i,        // continuous line-active
  input  wire logic        frame_i,       // frame-active
  output logic             pixel_rdy_o,   // pixel word accepted when high
  input  wire logic        slave_clk_i,   // slave shift clock pin
  input  wire logic        slave_data_i,  // slave serial data pin
  output logic             ser_clk_o,     // serial shift clock
  output logic             ser_data_o,    // serial data
  output logic             line_active_o, // formatted line-active
  output logic             sync_err_o     // sticky pair sync error
);

  typedef struct packed {
    logic [5:0]      ctrl_sh;
    logic [5:0]      ctrl_act;
    logic [5:0]      link;
    logic            sync_err;
    logic [31:0]     rdata;
    logic [9:0]      cur_pix;
    logic            cur_lv;
    logic            cur_fv;
    logic            have_cur;
    logic [3:0]      mark;
    logic            prev_lv;
    logic            prev_fv;
    logic [1:0]      rep;
    logic [3:0][7:0] hist;
    logic            rdy;
    logic            lv_out;
    logic            hold;
  } top_state_t;

  top_state_t  s_q;
  top_state_t  s_d;
  logic        take;
  logic [17:0] word;
  logic [7:0]  slave_byte;
  logic        slave_vld;

  // reserved word for a pending marker, lowest index goes first
  function automatic logic [7:0] mark_code(input logic [3:0] mark);
    logic [7:0] code;
    code = `RSV_FRAME_START;
    if (mark[0])
    begin
      code = `RSV_LINE_END;
    end
    else if (mark[1])
    begin
      code = `RSV_FRAME_END;
    end
    else if (mark[2])
    begin
      code = `RSV_FRAME_START;
    end
    else if (mark[3])
    begin
      code = `RSV_LINE_START;
    end
    return code;
  endfunction

  // keep real pixels off the reserved codes
  function automatic logic [9:0] subst(input logic [9:0] pix, input logic wide);
    logic [9:0] res;
    res = pix;
    if (wide && pix < {2'h0, `RSV_LIMIT})
    begin
      res = {2'h0, `SUBST_VALUE};
    end
    else if (!wide && pix[9:2] < `RSV_LIMIT)
    begin
      res = {`SUBST_VALUE, 2'h0};
    end
    return res;
  endfunction

  function automatic logic lv_format(input logic lv, input logic fv, input logic [1:0] fmt);
    logic res;
    case (lvds_serializer_pkg::lv_fmt_t'(fmt))
      lvds_serializer_pkg::LV_CONT:
      begin
        res = lv;
      end
      lvds_serializer_pkg::LV_XOR:
      begin
        res = lv ^ fv;
      end
      default:
      begin
        res = lv & fv;
      end
    endcase
    return res;
  endfunction

  function automatic logic [1:0] reps_m1(input logic [1:0] bin);
    logic [1:0] res;
    case (lvds_serializer_pkg::bin_t'(bin))
      lvds_serializer_pkg::BIN_TWO:
      begin
        res = 2'h1;
      end
      lvds_serializer_pkg::BIN_FOUR:
      begin
        res = 2'h3;
      end
      default:
      begin
        res = 2'h0;
      end
    endcase
    return res;
  endfunction

  logic       stereo;
  logic       wide;
  logic [1:0] bin;
  logic [1:0] lvfmt;
  logic [9:0] item_pix;
  logic       item_lv;
  logic       item_fv;
  logic       item_lvf;
  logic [7:0] merge_byte;

  assign stereo = s_q.ctrl_act[`CTRL_STEREO_BIT];
  assign wide   = s_q.ctrl_act[`CTRL_WIDE_BIT];
  assign bin    = s_q.ctrl_act[`CTRL_BIN_MSB:`CTRL_BIN_LSB];
  assign lvfmt  = s_q.ctrl_act[`CTRL_LVFMT_MSB:`CTRL_LVFMT_LSB];

  // item to send next: a marker, the held pixel, or an idle word
  always_comb
  begin
    item_lv = s_q.have_cur ? s_q.cur_lv : s_q.prev_lv;
    item_fv = s_q.have_cur ? s_q.cur_fv : s_q.prev_fv;
    if (|s_q.mark && !s_q.hold)
    begin
      if (wide && !stereo)
      begin
        item_pix = {2'h0, mark_code(s_q.mark)};
      end
      else
      begin
        item_pix = {mark_code(s_q.mark), 2'h0};
      end
    end
    else if (s_q.have_cur && !s_q.hold)
    begin
      item_pix = subst(s_q.cur_pix, wide && !stereo);
    end
    else
    begin
      item_pix = `IDLE_PIXEL;
    end
    item_lvf   = lv_format(item_lv, item_fv, lvfmt);
    merge_byte = s_q.hist[s_q.link[`LINK_LAT_MSB:`LINK_LAT_LSB]];
    if (stereo)
    begin
      word = {`STOP_BIT, merge_byte, item_pix[9:2], `START_BIT};
    end
    else if (wide)
    begin
      word = {6'h00, `STOP_BIT, item_pix, `START_BIT};
    end
    else
    begin
      word = {6'h00, `STOP_BIT, item_fv, item_lvf, item_pix[9:2], `START_BIT};
    end
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = 32'h0000_0000;

    // only outside a frame, so a paired sensor switches on the same frame
    if (!s_q.prev_fv)
    begin
      s_d.ctrl_act = s_q.ctrl_sh;
    end

    if (wr_i)
    begin
      case (addr_i)
        `REG_CTRL:
        begin
          s_d.ctrl_sh = wdata_i[5:0];
        end
        `REG_LINK:
        begin
          s_d.link = wdata_i[5:0];
        end
        `REG_STATUS:
        begin
          if (wdata_i[`STATUS_ERR_BIT])
          begin
            s_d.sync_err = 1'h0;
          end
        end
        default:
        begin
        end
      endcase
    end

    if (rd_i)
    begin
      case (addr_i)
        `REG_CTRL:
        begin
          s_d.rdata = {26'h0, s_q.ctrl_sh};
        end
        `REG_LINK:
        begin
          s_d.rdata = {26'h0, s_q.link};
        end
        `REG_STATUS:
        begin
          s_d.rdata    = {31'h0, s_q.sync_err};
          s_d.sync_err = 1'h0;
        end
        default:
        begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (slave_vld)
    begin
      s_d.hist = {s_q.hist[2:0], slave_byte};
    end

    if (take)
    begin
      s_d.lv_out = item_lvf;
      if (stereo && (item_pix[9:2] < `RSV_LIMIT || merge_byte < `RSV_LIMIT)
          && item_pix[9:2] != merge_byte)
      begin
        s_d.sync_err = 1'h1;
      end
      if (s_q.rep != reps_m1(bin))
      begin
        s_d.rep = s_q.rep + 2'h1;
      end
      else
      begin
        s_d.rep = 2'h0;
        if (s_q.hold)
        begin
          s_d.hold = 1'h0;
        end
        else if (s_q.mark[0])
        begin
          s_d.mark[0] = 1'h0;
        end
        else if (s_q.mark[1])
        begin
          s_d.mark[1] = 1'h0;
        end
        else if (s_q.mark[2])
        begin
          s_d.mark[2] = 1'h0;
        end
        else if (s_q.mark[3])
        begin
          s_d.mark[3] = 1'h0;
        end
        else
        begin
          s_d.have_cur = 1'h0;
        end
      end
    end

    if (pixel_vld_i && s_q.rdy)
    begin
      s_d.cur_pix  = pixel_i;
      s_d.cur_lv   = line_i;
      s_d.cur_fv   = frame_i;
      s_d.have_cur = 1'h1;
      s_d.hold     = s_d.rep != 2'h0;
      s_d.mark[0]  = s_q.prev_lv & ~line_i;
      s_d.mark[1]  = s_q.prev_fv & ~frame_i;
      s_d.mark[2]  = ~s_q.prev_fv & frame_i;
      s_d.mark[3]  = ~s_q.prev_lv & line_i;
      s_d.prev_lv  = line_i;
      s_d.prev_fv  = frame_i;
    end

    s_d.rdy = ~s_d.have_cur;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '{ctrl_sh: `CTRL_RST, ctrl_act: `CTRL_RST, link: `LINK_RST, sync_err: 1'h0,
               rdata: 32'h0000_0000, cur_pix: 10'h000, cur_lv: 1'h0, cur_fv: 1'h0,
               have_cur: 1'h0, mark: 4'h0, prev_lv: 1'h0, prev_fv: 1'h0, rep: 2'h0,
               hist: 32'h0000_0000, rdy: 1'h0, lv_out: 1'h0, hold: 1'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  packet_shifter u_shifter
  (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .word_i     (word),
    .stereo_i   (stereo),
    .take_o     (take),
    .ser_clk_o  (ser_clk_o),
    .ser_data_o (ser_data_o)
  );

  slave_link_rx u_slave_rx
  (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .link_clk_i  (slave_clk_i),
    .link_data_i (slave_data_i),
    .data_dly_i  (s_q.link[`LINK_DLY_MSB:`LINK_DLY_LSB]),
    .byte_o      (slave_byte),
    .byte_vld_o  (slave_vld)
  );

  assign rdata_o       = s_q.rdata;
  assign pixel_rdy_o   = s_q.rdy;
  assign line_active_o = s_q.lv_out;
  assign sync_err_o    = s_q.sync_err;

endmodule

/* rtl/lvds_serializer_defines.svh */
`ifndef LVDS_SERIALIZER_DEFINES_SVH
`define LVDS_SERIALIZER_DEFINES_SVH

// register offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_LINK          4'h8

// register field positions
`define CTRL_STEREO_BIT   0
`define CTRL_WIDE_BIT     1
`define CTRL_BIN_LSB      2
`define CTRL_BIN_MSB      3
`define CTRL_LVFMT_LSB    4
`define CTRL_LVFMT_MSB    5
`define STATUS_ERR_BIT    0
`define LINK_DLY_LSB      0
`define LINK_DLY_MSB      3
`define LINK_LAT_LSB      4
`define LINK_LAT_MSB      5

// reset values
`define CTRL_RST          6'h00
`define LINK_RST          6'h00

// packet layout
`define START_BIT         1'h1
`define STOP_BIT          1'h0
`define PKT_LAST_SOLO     5'h0B
`define PKT_LAST_STEREO   5'h11
`define RX_LAST_BIT       4'hB

// reserved words and substitution
`define RSV_FRAME_START   8'h00
`define RSV_LINE_START    8'h01
`define RSV_LINE_END      8'h02
`define RSV_FRAME_END     8'h03
`define RSV_LIMIT         8'h04
`define SUBST_VALUE       8'h04
`define IDLE_PIXEL        10'h010

// timing
`define SYS_CLK_PERIOD_NS 5
`define SER_BIT_NS        10
`define SER_HALF_CYCLES   (`SER_BIT_NS / (2 * `SYS_CLK_PERIOD_NS))

`endif

/* rtl/lvds_serializer_pkg.sv */
package lvds_serializer_pkg;

  typedef enum logic [1:0]
  {
    RX_IDLE = 2'h1,
    RX_BITS = 2'h2
  } rx_state_t;

  typedef enum logic [1:0]
  {
    LV_GATED = 2'h0,
    LV_CONT  = 2'h1,
    LV_XOR   = 2'h2,
    LV_SPARE = 2'h3
  } lv_fmt_t;

  typedef enum logic [1:0]
  {
    BIN_NONE  = 2'h0,
    BIN_TWO   = 2'h1,
    BIN_FOUR  = 2'h2,
    BIN_SPARE = 2'h3
  } bin_t;

endpackage

/* rtl/packet_shifter.sv */
`timescale 1ns/10ps
`include "lvds_serializer_defines.svh"

module packet_shifter
(
  input  wire logic        sys_clk_i,  // system clock
  input  wire logic        nrst_i,     // sync reset, active low
  input  wire logic [17:0] word_i,     // packet, bit 0 first
  input  wire logic        stereo_i,   // 18-bit packet length
  output logic             take_o,     // high the cycle after word_i is latched
  output logic             ser_clk_o,  // serial shift clock
  output logic             ser_data_o  // serial data
);

  typedef struct packed {
    logic [16:0] sh;
    logic [4:0]  cnt;
    logic [4:0]  last;
    logic [3:0]  div;
    logic        sclk;
    logic        sdat;
    logic        take;
  } shift_state_t;

  shift_state_t s_q;
  shift_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.take = 1'h0;
    if (s_q.div == 4'(`SER_HALF_CYCLES - 1))
    begin
      s_d.div  = 4'h0;
      s_d.sclk = ~s_q.sclk;
      if (s_q.sclk)
      begin
        // data changes on the falling edge, receiver samples on the rise
        if (s_q.cnt == s_q.last)
        begin
          s_d.sdat = word_i[0];
          s_d.sh   = word_i[17:1];
          s_d.cnt  = 5'h0;
          s_d.last = stereo_i ? `PKT_LAST_STEREO : `PKT_LAST_SOLO;
          s_d.take = 1'h1;
        end
        else
        begin
          s_d.sdat = s_q.sh[0];
          s_d.sh   = {1'h0, s_q.sh[16:1]};
          s_d.cnt  = s_q.cnt + 5'h1;
        end
      end
    end
    else
    begin
      s_d.div = s_q.div + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '{sh: 17'h0, cnt: `PKT_LAST_SOLO, last: `PKT_LAST_SOLO, div: 4'h0,
               sclk: 1'h0, sdat: 1'h0, take: 1'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign take_o     = s_q.take;
  assign ser_clk_o  = s_q.sclk;
  assign ser_data_o = s_q.sdat;

endmodule

/* rtl/slave_link_rx.sv */
`timescale 1ns/10ps
`include "lvds_serializer_defines.svh"

module slave_link_rx
(
  input  wire logic       sys_clk_i,   // system clock
  input  wire logic       nrst_i,      // sync reset, active low
  input  wire logic       link_clk_i,  // slave shift clock pin
  input  wire logic       link_data_i, // slave serial data pin
  input  wire logic [3:0] data_dly_i,  // sample delay after clock rise
  output logic [7:0]      byte_o,      // received slave byte
  output logic            byte_vld_o   // one-cycle pulse per byte
);

  typedef struct packed {
    logic [2:0]                       clk_s;
    logic [1:0]                       dat_s;
    logic                             pend;
    logic [3:0]                       wait_cnt;
    lvds_serializer_pkg::rx_state_t   st;
    logic [3:0]                       bit_cnt;
    logic [11:0]                      sh;
    logic [7:0]                       rx_byte;
    logic                             vld;
  } rx_reg_t;

  rx_reg_t s_q;
  rx_reg_t s_d;

  always_comb
  begin
    s_d       = s_q;
    s_d.vld   = 1'h0;
    s_d.clk_s = {s_q.clk_s[1:0], link_clk_i};
    s_d.dat_s = {s_q.dat_s[0], link_data_i};
    if (s_q.clk_s[1] && !s_q.clk_s[2])
    begin
      s_d.pend     = 1'h1;
      s_d.wait_cnt = data_dly_i;
    end
    else if (s_q.pend && s_q.wait_cnt != 4'h0)
    begin
      s_d.wait_cnt = s_q.wait_cnt - 4'h1;
    end
    else if (s_q.pend)
    begin
      s_d.pend = 1'h0;
      case (s_q.st)
        lvds_serializer_pkg::RX_IDLE:
        begin
          if (s_q.dat_s[1] == `START_BIT)
          begin
            s_d.st      = lvds_serializer_pkg::RX_BITS;
            s_d.bit_cnt = 4'h1;
          end
        end
        lvds_serializer_pkg::RX_BITS:
        begin
          s_d.sh[s_q.bit_cnt] = s_q.dat_s[1];
          s_d.bit_cnt         = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt == `RX_LAST_BIT)
          begin
            s_d.st = lvds_serializer_pkg::RX_IDLE;
            if (s_q.dat_s[1] == `STOP_BIT)
            begin
              s_d.rx_byte = s_q.sh[8:1];
              s_d.vld     = 1'h1;
            end
          end
        end
        default:
        begin
          s_d.st = lvds_serializer_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '{clk_s: 3'h0, dat_s: 2'h0, pend: 1'h0, wait_cnt: 4'h0,
               st: lvds_serializer_pkg::RX_IDLE, bit_cnt: 4'h0, sh: 12'h000,
               rx_byte: 8'h00, vld: 1'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign byte_o     = s_q.rx_byte;
  assign byte_vld_o = s_q.vld;

endmodule

/* verification/lvds_pixel_packet_serializer_monitor.sv */
`timescale 1ns/10ps
module serializer_monitor
(
  input  wire logic        sys_clk_i,     // system clock
  input  wire logic        nrst_i,        // sync reset
  input  wire logic [3:0]  addr_i,        // register address
  input  wire logic        wr_i,          // write strobe
  input  wire logic        rd_i,          // read strobe
  input  wire logic [31:0] rdata_o,       // read data
  input  wire logic        pixel_vld_i,   // pixel offered
  input  wire logic        pixel_rdy_o,   // pixel ready
  input  wire logic        ser_clk_o,     // shift clock
  input  wire logic        ser_data_o,    // serial data
  input  wire logic        line_active_o, // formatted line
  input  wire logic        sync_err_o     // pair error
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_shift_clk;
    $past(nrst_i) && $past(nrst_i, 2) |-> ser_clk_o != $past(ser_clk_o);
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock stalled");
  property p_data_fall;
    $changed(ser_data_o) |-> $fell(ser_clk_o);
  endproperty
  a_data_fall: assert property (p_data_fall) else $error("data moved off fall");
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_unmapped;
    $past(rd_i) && $past(addr_i) != 4'h0 && $past(addr_i) != 4'h4 && $past(addr_i) != 4'h8
      |-> rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status;
    $past(rd_i) && $past(addr_i) == 4'h4
      |-> rdata_o[31:1] == 31'h0 && (rdata_o[0] || !$past(sync_err_o));
  endproperty
  a_status: assert property (p_status) else $error("status read lost flag");
  property p_err_hold;
    sync_err_o && !rd_i && !wr_i |=> sync_err_o;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
  property p_rdy_drop;
    pixel_vld_i && pixel_rdy_o |=> !pixel_rdy_o;
  endproperty
  a_rdy_drop: assert property (p_rdy_drop) else $error("ready held after accept");
  property p_rdy_hold;
    pixel_rdy_o && !pixel_vld_i |=> pixel_rdy_o;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped idle");
  property p_rdy_back;
    pixel_vld_i && pixel_rdy_o |-> ##[2:800] pixel_rdy_o;
  endproperty
  a_rdy_back: assert property (p_rdy_back) else $error("ready never returned");
  property p_reset;
    disable iff (1'b0)
    !nrst_i |=> !pixel_rdy_o && !ser_clk_o && !ser_data_o && !sync_err_o && !line_active_o
      && rdata_o == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("output not cleared in reset");

  c_err: cover property ($rose(sync_err_o));
  c_status: cover property ($past(rd_i) && rdata_o[0]);
  c_line: cover property ($rose(line_active_o));
endmodule

bind lvds_pixel_packet_serializer serializer_monitor i_serializer_monitor
(
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pixel_vld_i(pixel_vld_i), .pixel_rdy_o(pixel_rdy_o),
  .ser_clk_o(ser_clk_o), .ser_data_o(ser_data_o), .line_active_o(line_active_o),
  .sync_err_o(sync_err_o)
);

/* verification/lvds_pixel_packet_serializer_tb_top.sv */
`timescale 1ns/10ps
module lvds_pixel_packet_serializer_tb_top;
  logic        sys_clk_i, nrst_i, wr_i, rd_i, pixel_vld_i, line_i, frame_i;
  logic        pixel_rdy_o, slave_clk_i, slave_data_i, ser_clk_o, ser_data_o;
  logic        line_active_o, sync_err_o, rx_stereo, rx_vld, rx_keep;
  logic [1:0]  rx_bin;
  logic [3:0]  addr_i;
  logic [9:0]  pixel_i;
  logic [17:0] rx_pkt;
  logic [31:0] wdata_i, rdata_o;
  logic [18:0] rxq[$];
  logic [9:0]  exq[$], exm[$];
  int          mismatches, checked, cycles;

  lvds_pixel_packet_serializer i_lvds_pixel_packet_serializer
  (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pixel_i(pixel_i),
    .pixel_vld_i(pixel_vld_i), .line_i(line_i), .frame_i(frame_i),
    .pixel_rdy_o(pixel_rdy_o), .slave_clk_i(slave_clk_i), .slave_data_i(slave_data_i),
    .ser_clk_o(ser_clk_o), .ser_data_o(ser_data_o), .line_active_o(line_active_o),
    .sync_err_o(sync_err_o)
  );
  pkt_deserializer i_pkt_deserializer
  (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ser_clk_i(ser_clk_o), .ser_data_i(ser_data_o),
    .stereo_i(rx_stereo), .bin_i(rx_bin), .pkt_o(rx_pkt), .pkt_vld_o(rx_vld),
    .keep_o(rx_keep), .mark_o()
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ceiling about five to six times the expected run length
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (rx_vld === 1'b1)
      rxq.push_back({rx_keep, rx_pkt});
    if (cycles == 20000)
    begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(posedge sys_clk_i);
    d = rdata_o;
  endtask

  task automatic restart(input logic [5:0] ctrl, input logic st, input logic [1:0] bn);
    nrst_i <= 1'b0;
    rx_stereo <= 1'b0;
    rx_bin <= bn;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    reg_wr(4'h0, {26'h0, ctrl});
    reg_wr(4'h8, 32'h0);
    // first packet still leaves with the reset control word
    repeat (30) @(posedge sys_clk_i);
    rx_stereo <= st;
    rxq.delete();
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    while (pixel_rdy_o !== 1'b1 && n < 900)
    begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic send_px(input logic [9:0] p, input logic l, input logic f);
    pixel_i <= p;
    line_i <= l;
    frame_i <= f;
    pixel_vld_i <= 1'b1;
    @(posedge sys_clk_i);
    wait_rdy();
    pixel_vld_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // slave sensor link, same clock and reset as this device
  task automatic send_slave(input logic [7:0] b);
    logic [11:0] p;
    p = {3'h0, b, 1'b1};
    for (int i = 0; i < 12; i++)
    begin
      slave_data_i <= p[i];
      repeat (16) @(posedge sys_clk_i);
      slave_clk_i <= 1'b1;
      repeat (16) @(posedge sys_clk_i);
      slave_clk_i <= 1'b0;
    end
    slave_data_i <= ~p[11];
    repeat (30) @(posedge sys_clk_i);
  endtask

  task automatic ex(input logic [9:0] v, input logic [9:0] m);
    exq.push_back(v);
    exm.push_back(m);
  endtask

  // drops idle packets, expects every remaining one rep times in a row
  task automatic check_stream(input int rep, input logic [9:0] idle, input logic [9:0] im);
    logic [9:0] pl;
    int         k;
    k = 0;
    wait_rdy();
    repeat (40) @(posedge sys_clk_i);
    foreach (rxq[i])
    begin
      pl = rxq[i][10:1];
      chk({rxq[i][11], rxq[i][0]}, 2'b01, "framing");
      if ((pl & im) !== idle && k < exq.size() * rep)
      begin
        chk(pl & exm[k / rep], exq[k / rep], "payload");
        if (k % rep == 0)
          chk(rxq[i][18], 1'b1, "group start");
        k++;
      end
    end
    chk(k, exq.size() * rep, "packet count");
    exq.delete();
    exm.delete();
  endtask

  task automatic t_solo8();
    restart(6'h00, 1'b0, 2'h0);
    ex(10'h000, 10'h0FF);
    ex(10'h001, 10'h0FF);
    ex(10'h3FF, 10'h3FF);
    send_px(10'h3FC, 1'b1, 1'b1);
    ex(10'h355, 10'h3FF);
    send_px(10'h155, 1'b1, 1'b1);
    ex(10'h002, 10'h0FF);
    ex(10'h240, 10'h3FF);
    send_px(10'h100, 1'b0, 1'b1);
    ex(10'h003, 10'h0FF);
    ex(10'h080, 10'h3FF);
    send_px(10'h200, 1'b0, 1'b0);
    check_stream(1, 10'h004, 10'h0FF);
    $display("t_solo8 done");
  endtask

  task automatic t_wide(input logic [1:0] bn, input int rep);
    restart({2'h0, bn, 2'h2}, 1'b0, bn);
    ex(10'h000, 10'h3FF);
    ex(10'h001, 10'h3FF);
    ex(10'h004, 10'h3FF);
    send_px(10'h002, 1'b1, 1'b1);
    ex(10'h3A5, 10'h3FF);
    send_px(10'h3A5, 1'b1, 1'b1);
    ex(10'h002, 10'h3FF);
    ex(10'h003, 10'h3FF);
    ex(10'h3A5, 10'h3FF);
    send_px(10'h3A5, 1'b0, 1'b0);
    check_stream(rep, 10'h010, 10'h3FF);
    $display("t_wide done, repeat %0d", rep);
  endtask

  task automatic t_lvfmt();
    logic [1:0] f;
    logic       e;
    for (int i = 0; i < 4; i++)
    begin
      f = i[1:0];
      restart({f, 4'h0}, 1'b0, 2'h0);
      for (int j = 1; j < 4; j++)
      begin
        send_px(10'h200, j[0], j[1]);
        wait_rdy();
        @(posedge sys_clk_i);
        e = (f == 2'h1) ? j[0] : (f == 2'h2) ? j[0] ^ j[1] : j[0] & j[1];
        chk(line_active_o, e, "line format");
      end
    end
    $display("t_lvfmt done");
  endtask

  task automatic t_stereo();
    logic [31:0] d;
    logic        hit;
    hit = 1'b0;
    restart(6'h01, 1'b1, 2'h0);
    send_slave(8'hA5);
    rxq.delete();
    send_px(10'h2A8, 1'b0, 1'b0);
    wait_rdy();
    repeat (50) @(posedge sys_clk_i);
    foreach (rxq[i])
      if (rxq[i][8:1] === 8'hAA)
      begin
        hit = 1'b1;
        chk({rxq[i][17:9], rxq[i][0]}, {1'b0, 8'hA5, 1'b1}, "stereo packet");
      end
    chk(hit, 1'b1, "master byte");
    reg_rd(4'h4, d);
    chk(d, 32'h1, "status");
    chk(sync_err_o, 1'b0, "flag cleared");
    reg_rd(4'h4, d);
    chk(d, 32'h0, "status after clear");
    send_slave(8'h00);
    chk(sync_err_o, 1'b1, "pair error");
    reg_rd(4'h0, d);
    chk(d, 32'h1, "control readback");
    reg_rd(4'hC, d);
    chk(d, 32'h0, "unmapped read");
    $display("t_stereo done");
  endtask

  initial
  begin
    mismatches = 0;
    checked = 0;
    cycles = 0;
    nrst_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pixel_i = 10'h000;
    pixel_vld_i = 1'b0;
    line_i = 1'b0;
    frame_i = 1'b0;
    slave_clk_i = 1'b0;
    slave_data_i = 1'b0;
    rx_stereo = 1'b0;
    rx_bin = 2'h0;
    t_solo8();
    t_wide(lvds_serializer_pkg::BIN_TWO, 2);
    t_wide(lvds_serializer_pkg::BIN_FOUR, 4);
    t_wide(lvds_serializer_pkg::BIN_SPARE, 1);
    t_lvfmt();
    t_stereo();
    report_and_stop();
  end
endmodule

/* verification/pkt_deserializer.sv */
`timescale 1ns/10ps
module pkt_deserializer
(
  input  wire logic        sys_clk_i,  // system clock
  input  wire logic        nrst_i,     // sync reset
  input  wire logic        ser_clk_i,  // shift clock
  input  wire logic        ser_data_i, // serial data
  input  wire logic        stereo_i,   // 18-bit packets
  input  wire logic [1:0]  bin_i,      // repeat code
  output logic      [17:0] pkt_o,      // packet, bit 0 first
  output logic             pkt_vld_o,  // packet pulse
  output logic             keep_o,     // first of a group
  output logic             mark_o      // reserved word seen
);
  logic        clk_q;
  logic        lock_q;
  logic [4:0]  cnt_q;
  logic [1:0]  grp_q;
  logic [1:0]  last_grp;
  logic [17:0] sr_q;

  assign last_grp = (bin_i == 2'h1) ? 2'h1 : (bin_i == 2'h2) ? 2'h3 : 2'h0;
  assign mark_o = pkt_o[8:1] < 8'h04;

  // locks on the first start bit after reset, then counts whole packets
  always_ff @(posedge sys_clk_i)
  begin
    clk_q <= ser_clk_i;
    pkt_vld_o <= 1'b0;
    if (!nrst_i)
    begin
      lock_q <= 1'b0;
      cnt_q <= 5'h00;
      grp_q <= 2'h0;
      sr_q <= 18'h00000;
    end
    else if (ser_clk_i && !clk_q && (lock_q || ser_data_i))
    begin
      lock_q <= 1'b1;
      sr_q[cnt_q] <= ser_data_i;
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == (stereo_i ? 5'h11 : 5'h0B))
      begin
        pkt_o <= sr_q;
        pkt_o[cnt_q] <= ser_data_i;
        pkt_vld_o <= 1'b1;
        keep_o <= grp_q == 2'h0;
        grp_q <= (grp_q == last_grp) ? 2'h0 : grp_q + 2'h1;
        cnt_q <= 5'h00;
        sr_q <= 18'h00000;
      end
    end
  end
endmodule
